//--- bench/pwpe_chk.sv
// port-level checks for the pin-enable and update control block
`timescale 1ns/10ps
`default_nettype none
module pwpe_chk
  import pwpe_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic control_write_lock_cfg,
  input wire logic pin_ownership_cfg,
  input wire logic tb_update_pulse,
  input wire pwpe_pins_t gpio_drive,
  input wire pwpe_pins_t gpio_oe,
  input wire pwpe_pins_t pin_out,
  input wire pwpe_pins_t pin_oe,
  input wire pwpe_pins_t pin_enable,
  input wire logic duty_pending
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed apb write
  wire logic wr_acc = psel && penable && pready && pwrite;
  // start-up: three wait cycles, then enables loaded from the config
  sequence s_boot;
    !pready [*3];
  endsequence
  sequence s_run;
    pready && pin_enable == {8{!pin_ownership_cfg}};
  endsequence
  ////////////////////////////////////////////////////////////////////
  a_boot_enable_load: assert property ($rose(presetn) |-> s_boot ##1 s_run)
    else $error("enables not loaded from ownership config");
  a_oe_follow: assert property ($past(presetn) |->
    pin_oe == ($past(pin_enable) | $past(gpio_oe))) else $error("pin enable routing");
  a_high_gpio: assert property ($past(presetn) |-> ((pin_out.high
    ^ $past(gpio_drive.high)) & ~$past(pin_enable.high)) == 4'h0) else $error("high gpio");
  a_low_gpio: assert property ($past(presetn) |-> ((pin_out.low
    ^ $past(gpio_drive.low)) & ~$past(pin_enable.low)) == 4'h0) else $error("low gpio");
  a_open_write: assert property (wr_acc && paddr == OFS_CTRL_ONE && !control_write_lock_cfg
    |-> !pslverr ##1 pin_enable == $past(pwdata[7:0])) else $error("open write lost");
  a_refused_hold: assert property (wr_acc && paddr == OFS_CTRL_ONE && pslverr
    |=> $stable(pin_enable)) else $error("refused write changed enables");
  a_err_in_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_pend_apply: assert property (tb_update_pulse && duty_pending
    && !(wr_acc && paddr == OFS_DUTY) |=> !duty_pending) else $error("pending not applied");
  a_pend_cause: assert property ($rose(duty_pending)
    |-> $past(wr_acc && paddr == OFS_DUTY)) else $error("pending without write");
endmodule : pwpe_chk
`default_nettype wire

//--- bench/pwpe_tb_top.sv
// self-checking bench for the pin-enable and update control block
`timescale 1ns/10ps
`default_nettype none
module pwpe_tb_top;
  import pwpe_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err, duty_pending;
  logic control_write_lock_cfg = 1'b0, pin_ownership_cfg = 1'b0, tb_update_pulse = 1'b0;
  pwpe_pins_t pwm_drive = 8'h3c, gpio_drive = 8'hc3, gpio_oe = 8'h00;
  pwpe_pins_t pin_out, pin_oe, pin_enable;
  logic [15:0] duty_active;
  int num_errors = 0, compares = 0;
  // 5 ns period
  always #2.5 pclk = ~pclk;
  pwpe_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .control_write_lock_cfg, .pin_ownership_cfg, .tb_update_pulse,
    .pwm_drive, .gpio_drive, .gpio_oe, .pin_out, .pin_oe, .pin_enable, .duty_active,
    .duty_pending);
  ////////////////////////////////////////////////////////////////////
  // compare and tally
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer: setup, then access held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // read right after the edge: these are the values the slave showed at that edge
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle cycle so the next call never re-raises psel in the same step
    @(posedge pclk);
  endtask : apb
  // reset held 20 cycles with the given config levels
  task automatic boot(input logic own, input logic lock);
    presetn <= 1'b0;
    pin_ownership_cfg <= own;
    control_write_lock_cfg <= lock;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
  endtask : boot
  // one-cycle time-base update point
  task automatic pulse;
    tb_update_pulse <= 1'b1;
    @(posedge pclk);
    tb_update_pulse <= 1'b0;
    @(posedge pclk);
  endtask : pulse
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    repeat (4000) @(posedge pclk);
    num_errors++;
    complete_run();
  end
  // main sequence
  initial begin
    boot(1'b0, 1'b0);
    // read data is captured at setup, so let the start-up load finish first
    repeat (4) @(posedge pclk);
    apb(1'b0, OFS_CTRL_ONE, 32'h0000_0000);
    chk(rd, 32'h0000_00ff);
    @(negedge pclk);
    chk(pin_oe, 32'h0000_00ff);
    @(posedge pclk);
    apb(1'b1, OFS_CTRL_ONE, 32'h0000_00a5);
    chk(err, 32'h0000_0000);
    apb(1'b0, OFS_CTRL_ONE, 32'h0000_0000);
    chk(rd, 32'h0000_00a5);
    @(negedge pclk);
    chk(pin_out, 32'h0000_0066);
    chk(pin_oe, 32'h0000_00a5);
    @(posedge pclk);
    $display("test pin routing done");
    // immediate duty, then time-base synchronous duty
    apb(1'b1, OFS_CTRL_TWO, 32'h0000_0004);
    apb(1'b1, OFS_DUTY, 32'h0000_1234);
    @(negedge pclk);
    chk(duty_active, 32'h0000_1234);
    @(posedge pclk);
    apb(1'b1, OFS_CTRL_TWO, 32'h0000_0000);
    apb(1'b1, OFS_DUTY, 32'h0000_5678);
    @(negedge pclk);
    chk(duty_active, 32'h0000_1234);
    chk(duty_pending, 32'h0000_0001);
    @(posedge pclk);
    pulse();
    @(negedge pclk);
    chk(duty_active, 32'h0000_5678);
    @(posedge pclk);
    $display("test duty update done");
    // override on low pin 0: next cycle, then held for the time base
    apb(1'b1, OFS_OVRD, 32'h0000_0101);
    @(negedge pclk);
    chk(pin_out, 32'h0000_0067);
    @(posedge pclk);
    apb(1'b1, OFS_CTRL_TWO, 32'h0000_0002);
    apb(1'b0, OFS_CTRL_TWO, 32'h0000_0000);
    chk(rd, 32'h0000_0002);
    apb(1'b1, OFS_OVRD, 32'h0000_0100);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(pin_out, 32'h0000_0067);
    @(posedge pclk);
    pulse();
    @(negedge pclk);
    chk(pin_out, 32'h0000_0066);
    @(posedge pclk);
    $display("test override sync done");
    // locked config: refused until unlocked
    boot(1'b1, 1'b1);
    // first request straight after release rides the start-up wait states
    apb(1'b1, OFS_CTRL_ONE, 32'h0000_00ff);
    chk(err, 32'h0000_0001);
    apb(1'b0, OFS_CTRL_ONE, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b1, OFS_UNLOCK, {16'h0000, UNLOCK_KEY_A});
    apb(1'b1, OFS_UNLOCK, {16'h0000, UNLOCK_KEY_B});
    // status: stage cleared, open set, lock config seen
    apb(1'b0, OFS_UNLOCK, 32'h0000_0000);
    chk(rd, 32'h0000_0006);
    apb(1'b1, OFS_CTRL_ONE, 32'h0000_00ff);
    chk(err, 32'h0000_0000);
    apb(1'b0, OFS_CTRL_ONE, 32'h0000_0000);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(err, 32'h0000_0001);
    $display("test write lock done");
    complete_run();
  end
endmodule : pwpe_tb_top
// checker beside the design top
bind pwpe_top pwpe_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .control_write_lock_cfg, .pin_ownership_cfg, .tb_update_pulse,
  .gpio_drive, .gpio_oe, .pin_out, .pin_oe, .pin_enable, .duty_pending);
`default_nettype wire

//--- hw/pwpe_apply.sv
// holding and active value pair with immediate or time-base-synchronous transfer
`timescale 1ns/10ps
`default_nettype none
module pwpe_apply #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_stb,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic immediate,
  input wire logic update_pulse,
  output logic [WIDTH-1:0] active_value,
  output logic [WIDTH-1:0] held_value,
  output logic pending
);
  logic [WIDTH-1:0] active_r, active_nxt; // value in use
  logic [WIDTH-1:0] held_r, held_nxt; // last written value
  logic pend_r, pend_nxt; // held value not yet applied

  // next-value logic
  always_comb begin
    active_nxt = active_r;
    held_nxt = held_r;
    pend_nxt = pend_r;
    // an update point first drains the older held value
    if (update_pulse && pend_r) begin
      active_nxt = held_r;
      pend_nxt = 1'b0;
    end
    if (wr_stb) begin
      held_nxt = wr_data;
      if (immediate) begin
        // write goes straight to the active copy
        active_nxt = wr_data;
        pend_nxt = 1'b0;
      end else begin
        // new write waits for the next update point; it wins over the drain
        pend_nxt = 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_r <= RST_VAL;
      held_r <= RST_VAL;
      pend_r <= 1'b0;
    end else begin
      active_r <= active_nxt;
      held_r <= held_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign active_value = active_r;
  assign held_value = held_r;
  assign pending = pend_r;
endmodule : pwpe_apply
`default_nettype wire

//--- hw/pwpe_top.sv
// apb register block for pwm pin ownership, control lock and update timing
//
// Functional notes
// - high-side enable 1 gives pin to pwm
// - low-side enable 1 gives pin to pwm
// - lock config 0 lets control one writes
// - enables reset to inverse of ownership config
// - immediate bit picks direct or synced duty
// - override sync bit picks time-base or next-cycle
`timescale 1ns/10ps
`default_nettype none
module pwpe_top #(
  parameter int DUTY_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pwpe_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic control_write_lock_cfg,
  input wire logic pin_ownership_cfg,
  input wire logic tb_update_pulse,
  input wire pwpe_pkg::pwpe_pins_t pwm_drive,
  input wire pwpe_pkg::pwpe_pins_t gpio_drive,
  input wire pwpe_pkg::pwpe_pins_t gpio_oe,
  output pwpe_pkg::pwpe_pins_t pin_out,
  output pwpe_pkg::pwpe_pins_t pin_oe,
  output pwpe_pkg::pwpe_pins_t pin_enable,
  output logic [DUTY_W-1:0] duty_active,
  output logic duty_pending
);
  import pwpe_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode helper
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////////
  // configuration inputs come from the fuse domain: two flops each
  logic lock_s1_r, lock_s2_r; // lock config synchroniser
  logic own_s1_r, own_s2_r; // ownership config synchroniser

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_s1_r <= 1'b0;
      lock_s2_r <= 1'b0;
      own_s1_r <= 1'b0;
      own_s2_r <= 1'b0;
    end else begin
      lock_s1_r <= control_write_lock_cfg;
      lock_s2_r <= lock_s1_r;
      own_s1_r <= pin_ownership_cfg;
      own_s2_r <= own_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // start-up: the enable reset value depends on a strap, which an async
  // reset cannot load, so the value is taken once the synchroniser has settled
  pwpe_init_t init_r, init_nxt; // start-up state

  always_comb begin
    case (init_r)
      INIT_SYNC0: init_nxt = INIT_SYNC1;
      INIT_SYNC1: init_nxt = INIT_LOAD;
      INIT_LOAD: init_nxt = INIT_RUN;
      INIT_RUN: init_nxt = INIT_RUN;
      default: init_nxt = INIT_SYNC0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_r <= INIT_SYNC0;
    end else begin
      init_r <= init_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb handshake and decode
  logic run; // registers usable
  logic setup_ph; // first apb cycle
  logic acc_ph; // completing apb cycle
  logic wr_acc; // write completes this edge
  logic mapped; // address decodes
  logic locked_now; // control one writes barred
  logic ct1_refused; // locked control one write

  assign run = (init_r == INIT_RUN);
  assign setup_ph = psel && !penable;
  assign acc_ph = psel && penable && run;
  assign wr_acc = acc_ph && pwrite;
  assign mapped = hit(paddr, OFS_CTRL_ONE) || hit(paddr, OFS_CTRL_TWO) ||
                  hit(paddr, OFS_UNLOCK) || hit(paddr, OFS_DUTY) || hit(paddr, OFS_OVRD);

  // wait states only until the start-up sequence is done
  assign pready = run;

  ////////////////////////////////////////////////////////////////////////////////
  // registers written by software
  pwpe_pins_t en_r, en_nxt; // pin enables, bits 7:4 high side, 3:0 low side
  logic iue_r, iue_nxt; // immediate duty update
  logic override_sync_select_r, override_sync_select_nxt; // override synced to time base
  logic stage_r, stage_nxt; // first key seen
  logic open_r, open_nxt; // unlock sequence complete

  // lock config 0: no sequence needed
  assign locked_now = lock_s2_r && !open_r;
  assign ct1_refused = wr_acc && hit(paddr, OFS_CTRL_ONE) && locked_now;
  // unmapped addresses and refused writes answer with an error
  assign pslverr = acc_ph && (!mapped || ct1_refused);

  always_comb begin
    en_nxt = en_r;
    iue_nxt = iue_r;
    override_sync_select_nxt = override_sync_select_r;
    stage_nxt = stage_r;
    open_nxt = open_r;
    if (init_r == INIT_LOAD) begin
      // ownership 0 gives pins to pwm, 1 leaves them as gpio
      en_nxt = own_s2_r ? 8'h00 : 8'hff;
    end
    if (wr_acc) begin
      // any write other than the first key clears the first-key stage
      stage_nxt = 1'b0;
      if (hit(paddr, OFS_CTRL_ONE)) begin
        if (!locked_now) begin
          en_nxt.high = pwdata[CT1_HIGH_LSB +: 4];
          en_nxt.low = pwdata[CT1_LOW_LSB +: 4];
        end
        // one write per unlock
        open_nxt = 1'b0;
      end else if (hit(paddr, OFS_CTRL_TWO)) begin
        iue_nxt = pwdata[CT2_IUE_BIT];
        override_sync_select_nxt = pwdata[CT2_OVERRIDE_SYNC_SELECT_BIT];
      end else if (hit(paddr, OFS_UNLOCK)) begin
        if (pwdata[15:0] == UNLOCK_KEY_A) begin
          stage_nxt = 1'b1;
        end else if (stage_r && pwdata[15:0] == UNLOCK_KEY_B) begin
          open_nxt = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= '0;
      iue_r <= CTRL_TWO_IUE_RST;
      override_sync_select_r <= CTRL_TWO_OVERRIDE_SYNC_SELECT_RST;
      stage_r <= 1'b0;
      open_r <= 1'b0;
    end else begin
      en_r <= en_nxt;
      iue_r <= iue_nxt;
      override_sync_select_r <= override_sync_select_nxt;
      stage_r <= stage_nxt;
      open_r <= open_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // duty and override transfer paths
  logic duty_wr; // duty register written
  logic ovr_wr; // override register written
  logic [15:0] ovr_active; // override in force
  logic [15:0] ovr_held; // override as written
  logic [DUTY_W-1:0] duty_held; // duty as written

  assign duty_wr = wr_acc && hit(paddr, OFS_DUTY);
  assign ovr_wr = wr_acc && hit(paddr, OFS_OVRD);

  // duty: direct when immediate bit set, else at the update point
  pwpe_apply #(
    .WIDTH(DUTY_W),
    .RST_VAL(DUTY_RST[DUTY_W-1:0])
  ) u_duty (
    .pclk(pclk),
    .presetn(presetn),
    .wr_stb(duty_wr),
    .wr_data(pwdata[DUTY_W-1:0]),
    .immediate(iue_r),
    .update_pulse(tb_update_pulse),
    .active_value(duty_active),
    .held_value(duty_held),
    .pending(duty_pending)
  );

  // override: next clock when sync bit clear, else at the update point
  pwpe_apply #(
    .WIDTH(16),
    .RST_VAL(OVRD_RST)
  ) u_ovr (
    .pclk(pclk),
    .presetn(presetn),
    .wr_stb(ovr_wr),
    .wr_data(pwdata[15:0]),
    .immediate(!override_sync_select_r),
    .update_pulse(tb_update_pulse),
    .active_value(ovr_active),
    .held_value(ovr_held),
    .pending()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pin steering, registered so the pads see no decode glitches
  pwpe_pins_t out_r, out_nxt; // pad level
  pwpe_pins_t oe_r, oe_nxt; // pad drive enable
  pwpe_pins_t ovr_en; // per-pin override enable
  pwpe_pins_t ovr_lvl; // per-pin override level

  assign ovr_en = ovr_active[OVR_ENABLE_LSB +: 8];
  assign ovr_lvl = ovr_active[OVR_LEVEL_LSB +: 8];

  always_comb begin
    // enable 1: pwm (or its override) drives; 0: gpio owns the pad
    out_nxt = (en_r & ((ovr_en & ovr_lvl) | (~ovr_en & pwm_drive))) |
              (~en_r & gpio_drive);
    oe_nxt = en_r | gpio_oe;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_r <= '0;
      oe_r <= '0;
    end else begin
      out_r <= out_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign pin_out = out_r;
  assign pin_oe = oe_r;
  assign pin_enable = en_r;

  ////////////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup cycle
  logic [31:0] rd_r, rd_nxt; // read data register

  always_comb begin
    rd_nxt = rd_r;
    if (setup_ph && !pwrite) begin
      rd_nxt = '0;
      if (hit(paddr, OFS_CTRL_ONE)) begin
        rd_nxt[CT1_HIGH_LSB +: 4] = en_r.high;
        rd_nxt[CT1_LOW_LSB +: 4] = en_r.low;
      end else if (hit(paddr, OFS_CTRL_TWO)) begin
        rd_nxt[CT2_IUE_BIT] = iue_r;
        rd_nxt[CT2_OVERRIDE_SYNC_SELECT_BIT] = override_sync_select_r;
      end else if (hit(paddr, OFS_UNLOCK)) begin
        rd_nxt[UNL_STAGE_BIT] = stage_r;
        rd_nxt[UNL_OPEN_BIT] = open_r;
        rd_nxt[UNL_LOCKCFG_BIT] = lock_s2_r;
      end else if (hit(paddr, OFS_DUTY)) begin
        rd_nxt[DUTY_W-1:0] = duty_held;
      end else if (hit(paddr, OFS_OVRD)) begin
        rd_nxt[15:0] = ovr_held;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign prdata = rd_r;
endmodule : pwpe_top
`default_nettype wire

//--- include/pwpe_pkg.sv
// constants, field layout and carrier types for the pwm pin-enable and update control block
package pwpe_pkg;
  // apb register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_UNLOCK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DUTY = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_OVRD = 8'h10;
  // field positions in pwm_control_one
  localparam int CT1_LOW_LSB = 0;
  localparam int CT1_HIGH_LSB = 4;
  // field positions in pwm_control_two
  localparam int CT2_OVERRIDE_SYNC_SELECT_BIT = 1;
  localparam int CT2_IUE_BIT = 2;
  // field positions in the override register
  localparam int OVR_LEVEL_LSB = 0;
  localparam int OVR_ENABLE_LSB = 8;
  // unlock register status bits
  localparam int UNL_STAGE_BIT = 0;
  localparam int UNL_OPEN_BIT = 1;
  localparam int UNL_LOCKCFG_BIT = 2;
  // reset values
  localparam logic CTRL_TWO_IUE_RST = 1'b0;
  localparam logic CTRL_TWO_OVERRIDE_SYNC_SELECT_RST = 1'b0;
  localparam logic [15:0] OVRD_RST = 16'h0000;
  localparam logic [15:0] DUTY_RST = 16'h0000;
  // two-step unlock keys, written to the unlock register in this order
  localparam logic [15:0] UNLOCK_KEY_A = 16'h5a5a;
  localparam logic [15:0] UNLOCK_KEY_B = 16'ha5a5;
  // eight output pins, four high side and four low side
  typedef struct packed {
    logic [3:0] high;
    logic [3:0] low;
  } pwpe_pins_t;
  // start-up sequence, gray along the path
  typedef enum logic [1:0] {
    INIT_SYNC0 = 2'b00,
    INIT_SYNC1 = 2'b01,
    INIT_LOAD = 2'b11,
    INIT_RUN = 2'b10
  } pwpe_init_t;
endpackage : pwpe_pkg
